// ===== rtl/idr_pkg.sv
// Package: parameter block word layout, fixed values and defaults
package idr_pkg;
   localparam int unsigned BLOCK_WORDS = 256;
   localparam int unsigned FIFO_DEPTH = 32;
   localparam int unsigned WORD_W = 16;
   // Word addresses
   localparam logic [7:0] W_GENCFG = 8'h00;
   localparam logic [7:0] W_DEF_CYL = 8'h01;
   localparam logic [7:0] W_DEF_HEAD = 8'h03;
   localparam logic [7:0] W_DEF_SPT = 8'h06;
   localparam logic [7:0] W_CARD_MSW = 8'h07;
   localparam logic [7:0] W_CARD_LSW = 8'h08;
   localparam logic [7:0] W_SER_FIRST = 8'h0A;
   localparam logic [7:0] W_SER_LAST = 8'h13;
   localparam logic [7:0] W_ECC = 8'h16;
   localparam logic [7:0] W_FW_FIRST = 8'h17;
   localparam logic [7:0] W_FW_LAST = 8'h1A;
   localparam logic [7:0] W_MOD_FIRST = 8'h1B;
   localparam logic [7:0] W_MOD_LAST = 8'h2E;
   localparam logic [7:0] W_MULT_MAX = 8'h2F;
   localparam logic [7:0] W_CAPAB = 8'h31;
   localparam logic [7:0] W_PIO_TIM = 8'h33;
   localparam logic [7:0] W_VALID = 8'h35;
   localparam logic [7:0] W_CUR_CYL = 8'h36;
   localparam logic [7:0] W_CUR_HEAD = 8'h37;
   localparam logic [7:0] W_CUR_SPT = 8'h38;
   localparam logic [7:0] W_CAP_LSW = 8'h39;
   localparam logic [7:0] W_CAP_MSW = 8'h3A;
   localparam logic [7:0] W_MULT_SET = 8'h3B;
   localparam logic [7:0] W_LBA_LSW = 8'h3C;
   localparam logic [7:0] W_LBA_MSW = 8'h3D;
   localparam logic [7:0] W_MWDMA = 8'h3F;
   localparam logic [7:0] W_ADV_PIO = 8'h40;
   localparam logic [7:0] W_MWDMA_MIN = 8'h41;
   localparam logic [7:0] W_MWDMA_REC = 8'h42;
   localparam logic [7:0] W_PIO_MIN = 8'h43;
   localparam logic [7:0] W_PIO_MIN_RDY = 8'h44;
   localparam logic [7:0] W_FEAT_FIRST = 8'h52;
   localparam logic [7:0] W_FEAT_LAST = 8'h57;
   localparam logic [7:0] W_UDMA = 8'h58;
   localparam logic [7:0] W_LAST = 8'hFF;
   // Fixed values
   localparam logic [15:0] V_GENCFG = 16'h044A;
   localparam logic [15:0] V_ECC = 16'h0004;
   localparam logic [15:0] V_PIO_TIM = 16'h0200;
   localparam logic [15:0] V_ADV_PIO = 16'h0003;
   localparam logic [15:0] V_UDMA = 16'h001F;
   localparam logic [15:0] V_ZERO = 16'h0000;
   localparam logic [15:0] V_MULT_SET_HI = 16'h0100;
   localparam logic [7:0] ASCII_SPACE = 8'h20;
   // Plain defaults for card-specific values
   localparam logic [15:0] D_CYL = 16'h0001;
   localparam logic [7:0] D_HEAD = 8'h01;
   localparam logic [15:0] D_SPT = 16'h0001;
   localparam logic [15:0] D_MULT_MAX = 16'h0001;
   localparam logic [15:0] D_PIO_MIN = 16'h0078;
   localparam logic [15:0] D_MWDMA_MODE = 16'h0000;
   localparam logic [15:0] D_MWDMA_TIME = 16'h0000;
   localparam logic [15:0] D_CAPAB = 16'h0000;
   localparam logic [15:0] D_VALID = 16'h0000;
   localparam logic [15:0] D_FEAT = 16'h0000;
   typedef enum logic [1:0] {
      IDR_IDLE = 2'b00,
      IDR_FILL = 2'b01,
      IDR_DRAIN = 2'b11,
      IDR_DONE = 2'b10
   } idr_state_e;
endpackage

// ===== rtl/idr_stream_if.sv
// Interface: valid/ready word stream between block builder and FIFO
`timescale 1ns/100ps
`default_nettype none
interface idr_stream_if #(parameter int W = 16);
   logic valid;
   logic ready;
   logic [W-1:0] data;
   modport src (output valid, output data, input ready);
   modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

// ===== rtl/idr_fifo.sv
// Module: parameterised valid/ready word FIFO
`timescale 1ns/100ps
`default_nettype none
module idr_fifo #(
   parameter int W = 16,
   parameter int DEPTH = 32
) (
   // Clock, enable, reset
   input wire logic clk,
   input wire logic ce,
   input wire logic rst_b,
   input wire logic clr,
   // Stream in and out
   idr_stream_if.snk in_s,
   idr_stream_if.src out_s
);
   localparam int AW = $clog2(DEPTH);
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } idr_fifo_s;
   idr_fifo_s st_r, st_nxt;
   logic [W-1:0] mem [DEPTH];
   logic push, pop;
   assign in_s.ready = (st_r.cnt != DEPTH[AW:0]);
   assign out_s.valid = (st_r.cnt != '0);
   assign out_s.data = mem[st_r.rp];
   assign push = in_s.valid && in_s.ready;
   assign pop = out_s.valid && out_s.ready;
   always_comb begin
      st_nxt = st_r;
      if (clr) begin
         st_nxt = '0;
      end else begin
         if (push) st_nxt.wp = st_r.wp + 1'b1;
         if (pop) st_nxt.rp = st_r.rp + 1'b1;
         if (push && !pop) st_nxt.cnt = st_r.cnt + 1'b1;
         if (pop && !push) st_nxt.cnt = st_r.cnt - 1'b1;
      end
   end
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         st_r <= '0;
      end else if (ce) begin
         st_r <= st_nxt;
      end
   end
   always_ff @(posedge clk) begin
      if (ce && push && !clr) mem[st_r.wp] <= in_s.data;
   end
   a_fifo_bound: assert property (@(posedge clk) disable iff (!rst_b)
      st_r.cnt <= DEPTH[AW:0]) else $error("fifo count beyond depth");
endmodule
`default_nettype wire

// ===== rtl/idr_word_gen.sv
// Module: combinational parameter block word lookup by address
`timescale 1ns/100ps
`default_nettype none
module idr_word_gen (
   // Address and word
   input wire logic [7:0] addr,
   output logic [15:0] word,
   // Geometry and capacity
   input wire logic [15:0] def_cyl,
   input wire logic [7:0] def_head,
   input wire logic [15:0] def_spt,
   input wire logic [15:0] cur_cyl,
   input wire logic [15:0] cur_head,
   input wire logic [15:0] cur_spt,
   input wire logic [31:0] card_sectors,
   input wire logic [31:0] cur_capacity,
   input wire logic [31:0] lba_sectors,
   input wire logic [7:0] mult_setting,
   input wire logic mem_mode,
   // Strings, first character in the top byte
   input wire logic [159:0] serial,
   input wire logic [63:0] firmware,
   input wire logic [319:0] model
);
   import idr_pkg::*;
   logic [7:0] si, fi, mi;
   always_comb begin
      si = addr - W_SER_FIRST;
      fi = addr - W_FW_FIRST;
      mi = addr - W_MOD_FIRST;
      word = V_ZERO;
      case (addr)
         W_GENCFG: word = V_GENCFG;
         W_DEF_CYL: word = def_cyl;
         W_DEF_HEAD: word = {8'h00, def_head};
         W_DEF_SPT: word = def_spt;
         W_CARD_MSW: word = card_sectors[31:16];
         W_CARD_LSW: word = card_sectors[15:0];
         W_ECC: word = V_ECC;
         W_MULT_MAX: word = D_MULT_MAX;
         W_CAPAB: word = D_CAPAB;
         W_PIO_TIM: word = V_PIO_TIM;
         W_VALID: word = D_VALID;
         W_CUR_CYL: word = cur_cyl;
         W_CUR_HEAD: word = cur_head;
         W_CUR_SPT: word = cur_spt;
         W_CAP_LSW: word = cur_capacity[15:0];
         W_CAP_MSW: word = cur_capacity[31:16];
         W_MULT_SET: word = V_MULT_SET_HI | {8'h00, mult_setting};
         W_LBA_LSW: word = lba_sectors[15:0];
         W_LBA_MSW: word = lba_sectors[31:16];
         W_MWDMA: word = mem_mode ? V_ZERO : D_MWDMA_MODE;
         W_ADV_PIO: word = V_ADV_PIO;
         W_MWDMA_MIN: word = mem_mode ? V_ZERO : D_MWDMA_TIME;
         W_MWDMA_REC: word = mem_mode ? V_ZERO : D_MWDMA_TIME;
         W_PIO_MIN: word = D_PIO_MIN;
         W_PIO_MIN_RDY: word = D_PIO_MIN;
         W_UDMA: word = V_UDMA;
         default: begin
            if (addr >= W_SER_FIRST && addr <= W_SER_LAST) begin
               word = serial[159 - 16*si[3:0] -: 16];
            end else if (addr >= W_FW_FIRST && addr <= W_FW_LAST) begin
               word = firmware[63 - 16*fi[1:0] -: 16];
            end else if (addr >= W_MOD_FIRST && addr <= W_MOD_LAST) begin
               word = model[319 - 16*mi[4:0] -: 16];
            end else if (addr >= W_FEAT_FIRST && addr <= W_FEAT_LAST) begin
               word = D_FEAT;
            end
         end
      endcase
   end
endmodule
`default_nettype wire

// ===== rtl/idr_responder.sv
// Module: parameter block responder feeding the sector data-in path
`timescale 1ns/100ps
`default_nettype none
module idr_responder #(
   parameter logic [15:0] DEF_CYL = idr_pkg::D_CYL,
   parameter logic [7:0] DEF_HEAD = idr_pkg::D_HEAD,
   parameter logic [15:0] DEF_SPT = idr_pkg::D_SPT
) (
   // Clock, enable, reset
   input wire logic CLK,
   input wire logic CE,
   input wire logic RST_B,
   // Command start and completion
   input wire logic START,
   output logic BUSY,
   output logic DONE,
   // Sector data-in path
   output logic DATA_VALID,
   output logic [15:0] DATA,
   input wire logic DATA_READY,
   // Card settings
   input wire logic [15:0] CUR_CYL,
   input wire logic [15:0] CUR_HEAD,
   input wire logic [15:0] CUR_SPT,
   input wire logic [31:0] CARD_SECTORS,
   input wire logic [31:0] CUR_CAPACITY,
   input wire logic [31:0] LBA_SECTORS,
   input wire logic [7:0] MULT_SETTING,
   input wire logic MEM_MODE,
   input wire logic [159:0] SERIAL,
   input wire logic [63:0] FIRMWARE,
   input wire logic [319:0] MODEL
);
   import idr_pkg::*;
   ////////////////////////////////////////////////////////////////////////
   typedef struct packed {
      idr_state_e st;
      logic [7:0] addr;
      logic [8:0] sent;
      logic busy;
      logic done;
      logic ovalid;
      logic [15:0] odata;
   } idr_resp_s;
   idr_resp_s s_r, s_nxt;
   logic [15:0] gen_word;
   logic fifo_clr;
   logic out_take;
   idr_stream_if #(.W(WORD_W)) fill_s ();
   idr_stream_if #(.W(WORD_W)) drain_s ();
   ////////////////////////////////////////////////////////////////////////
   idr_word_gen u_gen (
      .addr(s_r.addr),
      .word(gen_word),
      .def_cyl(DEF_CYL),
      .def_head(DEF_HEAD),
      .def_spt(DEF_SPT),
      .cur_cyl(CUR_CYL),
      .cur_head(CUR_HEAD),
      .cur_spt(CUR_SPT),
      .card_sectors(CARD_SECTORS),
      .cur_capacity(CUR_CAPACITY),
      .lba_sectors(LBA_SECTORS),
      .mult_setting(MULT_SETTING),
      .mem_mode(MEM_MODE),
      .serial(SERIAL),
      .firmware(FIRMWARE),
      .model(MODEL)
   );
   idr_fifo #(.W(WORD_W), .DEPTH(FIFO_DEPTH)) u_fifo (
      .clk(CLK),
      .ce(CE),
      .rst_b(RST_B),
      .clr(fifo_clr),
      .in_s(fill_s),
      .out_s(drain_s)
   );
   ////////////////////////////////////////////////////////////////////////
   // Builder pushes words in ascending order while the FIFO has room
   assign fill_s.valid = (s_r.st == IDR_FILL);
   assign fill_s.data = gen_word;
   assign fifo_clr = (s_r.st == IDR_IDLE) && START;
   // Output register: refill when empty or host took the word
   assign out_take = !s_r.ovalid || DATA_READY;
   assign drain_s.ready = out_take;
   always_comb begin
      s_nxt = s_r;
      s_nxt.done = 1'b0;
      if (out_take) begin
         s_nxt.ovalid = drain_s.valid;
         // Load only real words, so an empty FIFO never leaks stale or unknown data
         if (drain_s.valid) begin
            s_nxt.odata = drain_s.data;
         end
      end
      if (s_r.ovalid && DATA_READY) begin
         s_nxt.sent = s_r.sent + 9'h001;
      end
      case (s_r.st)
         IDR_IDLE: begin
            if (START) begin
               s_nxt.st = IDR_FILL;
               s_nxt.addr = 8'h00;
               s_nxt.sent = 9'h000;
               s_nxt.busy = 1'b1;
            end
         end
         IDR_FILL: begin
            if (fill_s.ready) begin
               s_nxt.addr = s_r.addr + 8'h01;
               if (s_r.addr == W_LAST) s_nxt.st = IDR_DRAIN;
            end
         end
         IDR_DRAIN: begin
            if (s_nxt.sent == BLOCK_WORDS[8:0]) begin
               s_nxt.st = IDR_DONE;
            end
         end
         IDR_DONE: begin
            s_nxt.busy = 1'b0;
            s_nxt.done = 1'b1;
            s_nxt.st = IDR_IDLE;
         end
         default: s_nxt.st = IDR_IDLE;
      endcase
   end
   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         s_r <= '0;
      end else if (CE) begin
         s_r <= s_nxt;
      end
   end
   assign BUSY = s_r.busy;
   assign DONE = s_r.done;
   assign DATA_VALID = s_r.ovalid;
   assign DATA = s_r.odata;
   ////////////////////////////////////////////////////////////////////////
   // Checks
   a_word_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.st == IDR_FILL && s_r.addr >= 8'h45 && s_r.addr <= 8'h51)
      |-> gen_word == 16'h0000) else $error("reserved word not zero");
   a_gencfg_val: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.st == IDR_FILL && s_r.addr == 8'h00) |-> gen_word == 16'h044A)
      else $error("word 0 wrong");
   a_head_upper: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h03) |-> gen_word[15:8] == 8'h00)
      else $error("head word upper byte set");
   a_card_order: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h07) |-> gen_word == CARD_SECTORS[31:16])
      else $error("card sectors order wrong");
   a_cap_order: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h39) |-> gen_word == CUR_CAPACITY[15:0])
      else $error("capacity order wrong");
   a_ecc_val: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h16) |-> gen_word == 16'h0004)
      else $error("word 22 wrong");
   a_model_first: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h1B) |-> gen_word == MODEL[319:304])
      else $error("model first word wrong");
   a_pio_val: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h33) |-> gen_word == 16'h0200)
      else $error("word 51 wrong");
   a_dma_mem: assert property (@(posedge CLK) disable iff (!RST_B)
      (MEM_MODE && (s_r.addr == 8'h3F || s_r.addr == 8'h41 || s_r.addr == 8'h42))
      |-> gen_word == 16'h0000) else $error("dma word not zero");
   a_adv_pio: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h40) |-> gen_word == 16'h0003)
      else $error("word 64 wrong");
   a_udma_val: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h58) |-> gen_word == 16'h001F)
      else $error("word 88 wrong");
   a_ata_ver: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr == 8'h50 || s_r.addr == 8'h51) |-> gen_word == 16'h0000)
      else $error("version words not zero");
   a_tail_zero: assert property (@(posedge CLK) disable iff (!RST_B)
      (s_r.addr >= 8'h5C) |-> gen_word == 16'h0000)
      else $error("tail word not zero");
   a_data_hold: assert property (@(posedge CLK) disable iff (!RST_B)
      (CE && DATA_VALID && !DATA_READY) |=> (DATA_VALID && $stable(DATA)))
      else $error("data dropped under stall");
   a_done_count: assert property (@(posedge CLK) disable iff (!RST_B)
      (CE && s_r.st == IDR_DONE) |-> s_r.sent == 9'h100)
      else $error("block not 256 words");
   a_addr_step: assert property (@(posedge CLK) disable iff (!RST_B)
      (CE && s_r.st == IDR_FILL && fill_s.ready && s_r.addr != 8'hFF)
      |=> s_r.addr == $past(s_r.addr) + 8'h01) else $error("address not ascending");
endmodule
`default_nettype wire

// ===== verification/idr_host_model.sv
// Host side model: collects parameter block words from the sector data-in path
`timescale 1ns/100ps
`default_nettype none
module idr_host_model (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_b,
   // Data-in path
   input wire logic data_valid,
   input wire logic [15:0] data,
   output logic data_ready,
   // Pacing and results
   input wire logic slow,
   input wire logic clear,
   output var int count,
   output var int held_bad
);
   logic [1:0] pace_r = 2'h0;
   logic [15:0] last_r;
   logic wait_r;
   logic [15:0] words [0:255];

   ////////////////////////////////////////////////////////////////////////////////
   // Slow mode accepts one cycle in four, so the FIFO fills behind the stall
   always @(negedge clk) begin
      pace_r <= pace_r + 2'h1;
   end
   assign data_ready = rst_b && (!slow || pace_r == 2'h2);

   ////////////////////////////////////////////////////////////////////////////////
   // Words kept in arrival order; obsolete ones are stored but never interpreted
   always @(posedge clk or negedge rst_b) begin
      if (!rst_b || clear) begin
         count <= 0;
         held_bad <= 0;
         wait_r <= 1'b0;
      end else begin
         // A pending word must stay put until it is taken
         if (wait_r && (data_valid !== 1'b1 || data !== last_r)) begin
            held_bad <= held_bad + 1;
         end
         wait_r <= data_valid && !data_ready;
         last_r <= data;
         if (data_valid && data_ready) begin
            if (count < 256) begin
               words[count] <= data;
            end
            count <= count + 1;
         end
      end
   end
endmodule
`default_nettype wire

// ===== verification/testbench.sv
// Testbench: parameter block responder against a host model
`timescale 1ns/100ps
`default_nettype none
module testbench;
   import idr_pkg::*;
   localparam logic [15:0] T_CYL = 16'h1F2E;
   localparam logic [7:0] T_HEAD = 8'hA5;
   localparam logic [15:0] T_SPT = 16'h003F;
   logic clk = 1'b0;
   logic rst_b = 1'b0;
   logic start = 1'b0;
   logic ce = 1'b1;
   logic busy, done, data_valid, data_ready;
   logic [15:0] data;
   logic [15:0] cur_cyl = 16'h03E1;
   logic [15:0] cur_head = 16'h0010;
   logic [15:0] cur_spt = 16'h003E;
   logic [31:0] card_sectors = 32'h000F_4240;
   logic [31:0] cur_capacity = 32'h0012_3456;
   logic [31:0] lba_sectors = 32'h0ABC_DEF0;
   logic [7:0] mult_setting = 8'h10;
   logic mem_mode = 1'b0;
   logic [159:0] serial = "      SN0042XY7Q9Z01";
   logic [63:0] firmware = "FW 1.0.3";
   logic [319:0] model = {"FLASH MODULE X21", {24{8'h20}}};
   logic slow = 1'b0;
   logic clear = 1'b0;
   int host_count, host_bad;
   int n_errors = 0;
   int comparisons = 0;

   idr_responder #(.DEF_CYL(T_CYL), .DEF_HEAD(T_HEAD), .DEF_SPT(T_SPT)) u_idr_responder (
      .CLK(clk), .CE(ce), .RST_B(rst_b), .START(start), .BUSY(busy), .DONE(done),
      .DATA_VALID(data_valid), .DATA(data), .DATA_READY(data_ready),
      .CUR_CYL(cur_cyl), .CUR_HEAD(cur_head), .CUR_SPT(cur_spt),
      .CARD_SECTORS(card_sectors), .CUR_CAPACITY(cur_capacity), .LBA_SECTORS(lba_sectors),
      .MULT_SETTING(mult_setting), .MEM_MODE(mem_mode), .SERIAL(serial),
      .FIRMWARE(firmware), .MODEL(model));

   idr_host_model u_idr_host_model (
      .clk(clk), .rst_b(rst_b), .data_valid(data_valid), .data(data),
      .data_ready(data_ready), .slow(slow), .clear(clear), .count(host_count),
      .held_bad(host_bad));

   initial begin
      forever #20 clk = ~clk;
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Comparisons and the expected block
   task automatic check_word(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic check_flag(input logic got, input logic exp, input string what);
      comparisons++;
      if (got !== exp) begin
         n_errors++;
         $display("BAD %0t %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic check_int(input int got, input int exp, input string what);
      comparisons++;
      if (got != exp) begin
         n_errors++;
         $display("BAD %0t %s got %0d expected %0d", $time, what, got, exp);
      end
   endtask

   function automatic logic [15:0] exp_word(input int a);
      if (a >= 10 && a <= 19) return serial[159 - 16 * (a - 10) -: 16];
      if (a >= 23 && a <= 26) return firmware[63 - 16 * (a - 23) -: 16];
      if (a >= 27 && a <= 46) return model[319 - 16 * (a - 27) -: 16];
      if (a >= 82 && a <= 87) return D_FEAT;
      case (a)
         0: return 16'h044A;
         1: return T_CYL;
         3: return {8'h00, T_HEAD};
         6: return T_SPT;
         7: return card_sectors[31:16];
         8: return card_sectors[15:0];
         22: return 16'h0004;
         47: return D_MULT_MAX;
         49: return D_CAPAB;
         51: return 16'h0200;
         53: return D_VALID;
         54: return cur_cyl;
         55: return cur_head;
         56: return cur_spt;
         57: return cur_capacity[15:0];
         58: return cur_capacity[31:16];
         59: return {8'h01, mult_setting};
         60: return lba_sectors[15:0];
         61: return lba_sectors[31:16];
         63: return mem_mode ? 16'h0000 : D_MWDMA_MODE;
         64: return 16'h0003;
         65, 66: return mem_mode ? 16'h0000 : D_MWDMA_TIME;
         67, 68: return D_PIO_MIN;
         88: return 16'h001F;
         default: return 16'h0000;
      endcase
   endfunction

   // Obsolete words and words outside this block's scope are not judged
   function automatic bit ignored(input int a);
      return a inside {4, 5, 9, 20, 21, 52} || (a >= 89 && a <= 91) || (a >= 128 && a <= 167);
   endfunction

   task automatic check_block();
      check_int(host_count, 256, "word count");
      check_int(host_bad, 0, "pending word changed");
      for (int a = 0; a < 256; a++) begin
         if (!ignored(a)) begin
            check_word(u_idr_host_model.words[a], exp_word(a), $sformatf("word %0d", a));
         end
      end
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Shared steps
   task automatic launch();
      clear = 1'b1;
      @(negedge clk);
      clear = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
   endtask

   task automatic wait_done(input int limit);
      int n;
      n = 0;
      while (done !== 1'b1 && n < limit) begin
         @(negedge clk);
         n++;
      end
      check_flag(done, 1'b1, "completion pulse");
      check_flag(busy, 1'b0, "busy at completion");
      @(negedge clk);
      check_flag(done, 1'b0, "completion pulse length");
   endtask

   task automatic check_idle(input string what);
      check_flag(busy, 1'b0, what);
      check_flag(done, 1'b0, what);
      check_flag(data_valid, 1'b0, what);
      check_word(data, 16'h0000, what);
   endtask

   ////////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic test_fast();
      slow = 1'b0;
      mem_mode = 1'b0;
      launch();
      @(negedge clk);
      check_flag(busy, 1'b1, "busy after start");
      check_flag(data_valid, 1'b0, "early word");
      @(negedge clk);
      check_flag(data_valid, 1'b1, "first word late");
      check_word(data, 16'h044A, "first word");
      wait_done(600);
      check_block();
      $display("test fast host done");
   endtask

   task automatic test_slow_refused();
      slow = 1'b1;
      mem_mode = 1'b1;
      card_sectors = 32'hFFFF_0001;
      cur_capacity = 32'h8000_7FFF;
      lba_sectors = 32'h0001_FFFE;
      cur_head = 16'h00FF;
      mult_setting = 8'hFF;
      launch();
      repeat (20) @(negedge clk);
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      wait_done(2000);
      check_block();
      repeat (10) @(negedge clk);
      check_flag(busy, 1'b0, "start while busy restarted");
      check_flag(data_valid, 1'b0, "start while busy restarted");
      $display("test stalling host and refused start done");
   endtask

   task automatic test_abort();
      slow = 1'b1;
      launch();
      repeat (40) @(negedge clk);
      rst_b = 1'b0;
      @(negedge clk);
      check_idle("outputs during reset");
      rst_b = 1'b1;
      @(negedge clk);
      check_idle("outputs after reset");
      test_fast();
      $display("test reset mid block done");
   endtask

   task automatic test_freeze();
      ce = 1'b0;
      start = 1'b1;
      @(negedge clk);
      start = 1'b0;
      repeat (3) @(negedge clk);
      ce = 1'b1;
      check_flag(busy, 1'b0, "start taken while frozen");
      @(negedge clk);
      check_flag(busy, 1'b0, "start kept after freeze");
      check_flag(data_valid, 1'b0, "word while frozen");
      test_fast();
      $display("test clock enable freeze done");
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", comparisons, n_errors);
      if (n_errors == 0 && comparisons > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      #400000;
      n_errors++;
      $display("BAD %0t watchdog expired", $time);
      complete_run();
   end

   initial begin
      repeat (8) @(negedge clk);
      check_idle("outputs in reset");
      rst_b = 1'b1;
      test_fast();
      test_slow_refused();
      test_abort();
      test_freeze();
      complete_run();
   end
endmodule
`default_nettype wire
